/* hdc_addr_dec.sv */
// hdc_addr_dec: splits a configuration map byte address into scalar and string storage hits
// assumes the address is stable for the cycle it is decoded in
`timescale 1ns/100ps
module hdc_addr_dec (
    input  wire logic [7:0] addr,
    output logic            scalar_hit,
    output logic [2:0]      scalar_idx,
    output logic            text_hit,
    output logic [6:0]      text_idx
);
    logic [7:0] scalar_off;
    logic [7:0] text_off;

    assign scalar_off = addr - hdc_pkg::HDC_OFS_SP_CUR;
    assign text_off   = addr - hdc_pkg::HDC_OFS_MAKER_FIRST;
    assign scalar_hit = (addr >= hdc_pkg::HDC_OFS_SP_CUR) && (addr <= hdc_pkg::HDC_OFS_SERIAL_LEN);
    assign scalar_idx = scalar_off[2:0];
    // both strings share one contiguous store, maker first then product
    assign text_hit   = (addr >= hdc_pkg::HDC_OFS_MAKER_FIRST) && (addr <= hdc_pkg::HDC_OFS_PRODUCT_LAST);
    assign text_idx   = text_off[6:0];
endmodule // hdc_addr_dec

/* hdc_cfg_master.sv */
// config master model: byte writes and reads on the serial slave port
// assumes the bench calls one task at a time
`timescale 1ns/100ps
module hdc_cfg_master (
    input logic                   clk,
    output hdc_pkg::hdc_cfg_req_t cfg_req
);
    initial cfg_req = '0;
    // one beat per edge; strings go out low byte first, ascending
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{w, r, a, d};
    endtask
    // stale address and data are inverted so an idle port never mirrors the last beat
    task automatic idle;
        @(posedge clk);
        cfg_req <= '{1'b0, 1'b0, ~cfg_req.addr, ~cfg_req.wdata};
    endtask
endmodule // hdc_cfg_master

/* hdc_config_bank.sv */
// hdc_config_bank: hub descriptor slice of the byte-wide configuration map
// assumes one configuration master on the serial slave port and a descriptor engine reading values
//
// Operation
// - self-powered controller current, 8 bits in 1 mA units, resets to 02h
// - self-powered current excludes any permanently attached embedded peripheral
// - bus-powered controller current, 8 bits in 1 mA units, resets to 64h
// - power-on time, 8 bits in 2 ms units, resets to zero
// - power-on time only feeds the hub descriptor power-on-to-good field
// - language id upper register supplies bits 15:8, resets to 04h
// - language id lower register supplies bits 7:0, resets to 09h
// - maker, product, serial string lengths at 13h, 14h, 15h, reset zero
// - maker string bytes at 16h through 53h, each resets to zero
// - product string bytes at 54h through 91h, each resets to zero
// - each utf-16le character takes two addresses, low byte first
`timescale 1ns/100ps
module hdc_config_bank (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire hdc_pkg::hdc_cfg_req_t    cfg_req,
    output logic [7:0]                    cfg_rdata_q,
    output logic                          cfg_rvalid_q,
    input  wire logic                     desc_rd,
    input  wire hdc_pkg::hdc_text_sel_t   desc_sel,
    input  wire logic [4:0]               desc_char_idx,
    output logic [15:0]                   desc_char_q,
    output logic                          desc_char_valid_q,
    output hdc_pkg::hdc_desc_values_t     desc_values
);
    logic [7:0]  scalar_q [hdc_pkg::HDC_SCALARS];
    logic        scalar_hit;
    logic [2:0]  scalar_idx;
    logic        text_hit;
    logic [6:0]  text_idx;
    logic        scalar_wr;
    logic        text_wr;
    logic [7:0]  text_rd_byte;
    logic [15:0] text_char;
    logic [6:0]  char_base;
    logic        char_ok;
    logic [7:0]  cfg_rdata_d;
    logic [15:0] desc_char_d;

    // first stage of the read pipelines
    logic        rd_s1_q;
    logic        rd_scalar_s1_q;
    logic        rd_text_s1_q;
    logic [7:0]  scalar_data_s1_q;
    logic        desc_rd_s1_q;
    logic        desc_ok_s1_q;

    hdc_addr_dec u_dec (
        .addr       (cfg_req.addr),
        .scalar_hit (scalar_hit),
        .scalar_idx (scalar_idx),
        .text_hit   (text_hit),
        .text_idx   (text_idx)
    );

    // writes outside 0eh..91h belong to other parts of the map and are ignored here
    assign scalar_wr = cfg_req.wr && scalar_hit;
    assign text_wr   = cfg_req.wr && text_hit;

    // a character index past the last one would run off the product string
    assign char_ok   = (desc_char_idx <= hdc_pkg::HDC_LAST_CHAR);
    assign char_base = ((desc_sel == hdc_pkg::HDC_TEXT_PRODUCT) ? hdc_pkg::HDC_STR_BYTES : 7'h00)
                       + {1'b0, desc_char_idx, 1'b0};

    hdc_text_mem u_mem (
        .clk         (clk),
        .resetn      (resetn),
        .wr_en       (text_wr),
        .wr_idx      (text_idx),
        .wr_data     (cfg_req.wdata),
        .rd_idx      (text_idx),
        .rd_data_q   (text_rd_byte),
        .char_base   (char_ok ? char_base : 7'h00),
        .char_data_q (text_char)
    );

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < hdc_pkg::HDC_SCALARS; i++)
                scalar_q[i] <= hdc_pkg::hdc_scalar_reset(3'(i));
        end
        else if (scalar_wr)
            scalar_q[scalar_idx] <= cfg_req.wdata;
    end

    // read returns the value held before a write in the same cycle
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rd_s1_q          <= 1'b0;
            rd_scalar_s1_q   <= 1'b0;
            rd_text_s1_q     <= 1'b0;
            scalar_data_s1_q <= 8'h00;
            desc_rd_s1_q     <= 1'b0;
            desc_ok_s1_q     <= 1'b0;
        end
        else
        begin
            rd_s1_q          <= cfg_req.rd;
            rd_scalar_s1_q   <= cfg_req.rd && scalar_hit;
            rd_text_s1_q     <= cfg_req.rd && text_hit;
            scalar_data_s1_q <= scalar_q[scalar_idx];
            desc_rd_s1_q     <= desc_rd;
            desc_ok_s1_q     <= desc_rd && char_ok;
        end
    end

    // unmapped addresses read as zero
    assign cfg_rdata_d = rd_text_s1_q   ? text_rd_byte :
                         rd_scalar_s1_q ? scalar_data_s1_q : 8'h00;
    assign desc_char_d = desc_ok_s1_q ? text_char : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg_rdata_q       <= 8'h00;
            cfg_rvalid_q      <= 1'b0;
            desc_char_q       <= 16'h0000;
            desc_char_valid_q <= 1'b0;
        end
        else
        begin
            cfg_rdata_q       <= cfg_rdata_d;
            cfg_rvalid_q      <= rd_s1_q;
            desc_char_q       <= desc_char_d;
            desc_char_valid_q <= desc_rd_s1_q;
        end
    end

    // descriptor values come straight from the scalar flops
    assign desc_values.self_powered_controller_current = scalar_q[0];
    assign desc_values.bus_powered_controller_current  = scalar_q[1];
    assign desc_values.power_on_to_good_time           = scalar_q[2];
    assign desc_values.language_id                     = {scalar_q[3], scalar_q[4]};
    assign desc_values.maker_text_length               = scalar_q[5];
    assign desc_values.product_text_length             = scalar_q[6];
    assign desc_values.serial_text_length              = scalar_q[7];
endmodule // hdc_config_bank

/* hdc_config_bank_bench.sv */
// bench for the hub descriptor bank: master model, scoreboard queues, mid-run reset
// assumes the checker binds itself onto the bank
`timescale 1ns/100ps
module hdc_config_bank_bench;
    logic                      clk = 1'b0;
    logic                      resetn = 1'b0;
    logic                      drd = 1'b0;
    hdc_pkg::hdc_text_sel_t    dsel = hdc_pkg::HDC_TEXT_MAKER;
    logic [4:0]                didx = 5'h00;
    hdc_pkg::hdc_cfg_req_t     req;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic                      dvalid;
    logic [15:0]               dchar;
    hdc_pkg::hdc_desc_values_t vals;
    logic [7:0]                m [256];
    logic [15:0]               qc [$], qd [$];
    int                        bad_count = 0, check_count = 0, cyc = 0;
    always #25 clk = ~clk;
    hdc_cfg_master u_master (.clk(clk), .cfg_req(req));
    hdc_config_bank dut (.clk(clk), .resetn(resetn), .cfg_req(req), .cfg_rdata_q(rdata), .cfg_rvalid_q(rvalid),
        .desc_rd(drd), .desc_sel(dsel), .desc_char_idx(didx), .desc_char_q(dchar), .desc_char_valid_q(dvalid),
        .desc_values(vals));
    task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] s);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // one compare per kind of result, all funnelled through the same counters
    task automatic cmp_rdata(input logic [15:0] e, input logic [7:0] s);
        cmp("read data", 64'(e), 64'(s));
    endtask
    task automatic cmp_char(input logic [15:0] e, input logic [15:0] s);
        cmp("string char", 64'(e), 64'(s));
    endtask
    task automatic cmp_values(input logic [63:0] e, input logic [63:0] s);
        cmp("values", e, s);
    endtask
    task automatic final_report;
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // the read is queued before the model update, so a same-cycle read expects the old byte
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        u_master.xfer(w, r, a, d);
        if (r)
            qc.push_back((a >= 8'h0e && a <= 8'h91) ? m[a] : 8'h00);
        if (w && a >= 8'h0e && a <= 8'h91)
            m[a] = d;
    endtask
    task automatic dr(input logic s, input logic [4:0] i);
        logic [7:0] b;
        b = (s ? 8'h54 : 8'h16) + {2'b00, i, 1'b0};
        @(posedge clk);
        drd <= 1'b1;
        dsel <= hdc_pkg::hdc_text_sel_t'(s);
        didx <= i;
        qd.push_back((i == 5'h1f) ? 16'h0000 : {m[b + 8'h01], m[b]});
    endtask
    task automatic reset_all;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        foreach (m[i]) m[i] = 8'h00;
        m[14] = 8'h02;
        m[15] = 8'h64;
        m[17] = 8'h04;
        m[18] = 8'h09;
    endtask
    task automatic chk_vals;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp_values({m[14], m[15], m[16], m[17], m[18], m[19], m[20], m[21]}, vals);
    endtask
    // walks one address past each end of the slice; self-powered current kept within 100 mA
    task automatic sweep(input logic w);
        for (int a = 8'h0d; a <= 8'h92; a++)
            acc(w, !w, 8'(a), (a == 8'h0e) ? 8'($urandom % 101) : 8'($urandom));
        u_master.idle();
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rvalid === 1'b1)
            cmp_rdata((qc.size() > 0) ? qc.pop_front() : 'x, rdata);
        if (dvalid === 1'b1)
            cmp_char((qd.size() > 0) ? qd.pop_front() : 'x, dchar);
        if (cyc == 3000)
        begin
            bad_count++;
            final_report();
        end
    end
    initial
    begin
        void'($urandom(32'hefbdf09e));
        reset_all();
        chk_vals();
        sweep(1'b0);
        sweep(1'b1);
        sweep(1'b0);
        acc(1'b1, 1'b1, 8'h30, 8'h5a);
        acc(1'b0, 1'b1, 8'h30, 8'h00);
        u_master.idle();
        for (int k = 0; k < 64; k++) dr(k[5], k[4:0]);
        @(posedge clk);
        drd <= 1'b0;
        chk_vals();
        acc(1'b1, 1'b0, 8'h10, 8'h00);
        u_master.idle();
        chk_vals();
        reset_all();
        chk_vals();
        sweep(1'b0);
        repeat (4) @(posedge clk);
        cmp("pending answers", 64'(qc.size() + qd.size()), 64'h0);
        final_report();
    end
endmodule // hdc_config_bank_bench

/* hdc_config_bank_sva.sv */
// bank checker: config port timing and register write-through
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module hdc_config_bank_sva (
    input logic                      clk,
    input logic                      resetn,
    input hdc_pkg::hdc_cfg_req_t     cfg_req,
    input logic [7:0]                cfg_rdata_q,
    input logic                      cfg_rvalid_q,
    input logic                      desc_rd,
    input logic [4:0]                desc_char_idx,
    input logic [15:0]               desc_char_q,
    input logic                      desc_char_valid_q,
    input hdc_pkg::hdc_desc_values_t desc_values
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rd_lat; cfg_req.rd |-> ##2 cfg_rvalid_q; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
    property p_rd_cause; cfg_rvalid_q |-> $past(cfg_req.rd, 2); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("unrequested read answer");
    property p_sp; cfg_req.wr && cfg_req.addr == 8'h0e |=> desc_values[63:56] == $past(cfg_req.wdata); endproperty
    a_sp: assert property (p_sp) else $error("self powered current not stored");
    property p_bp; cfg_req.wr && cfg_req.addr == 8'h0f |=> desc_values[55:48] == $past(cfg_req.wdata); endproperty
    a_bp: assert property (p_bp) else $error("bus powered current not stored");
    // outside an answer the data outputs must rest at zero
    property p_rd_idle; !cfg_rvalid_q |-> cfg_rdata_q == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
    property p_char_idle; !desc_char_valid_q |-> desc_char_q == 16'h0000; endproperty
    a_char_idle: assert property (p_char_idle) else $error("string char not zero outside answer");
    property p_pwr; $changed(desc_values[47:40]) |-> $past(cfg_req.wr) && $past(cfg_req.addr) == 8'h10; endproperty
    a_pwr: assert property (p_pwr) else $error("power on time changed without write");
    property p_lang_up; cfg_req.wr && cfg_req.addr == 8'h11 |=> desc_values[39:32] == $past(cfg_req.wdata); endproperty
    a_lang_up: assert property (p_lang_up) else $error("language upper not stored");
    property p_lang_lo; cfg_req.wr && cfg_req.addr == 8'h12 |=> desc_values[31:24] == $past(cfg_req.wdata); endproperty
    a_lang_lo: assert property (p_lang_lo) else $error("language lower not stored");
    property p_len; cfg_req.wr && cfg_req.addr == 8'h15 |=> desc_values[7:0] == $past(cfg_req.wdata); endproperty
    a_len: assert property (p_len) else $error("serial length not stored");
    property p_end; desc_rd && desc_char_idx == 5'h1f |-> ##2 desc_char_valid_q && desc_char_q == 16'h0000; endproperty
    a_end: assert property (p_end) else $error("char past string end not zero");
endmodule // hdc_config_bank_sva
bind hdc_config_bank hdc_config_bank_sva u_sva (.clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .desc_rd(desc_rd), .desc_char_idx(desc_char_idx), .desc_char_q(desc_char_q),
    .desc_char_valid_q(desc_char_valid_q), .desc_values(desc_values));

/* hdc_pkg.sv */
// hub descriptor configuration bank: shared offsets, reset values and types
// assumes a byte-wide configuration map reached through the serial slave port
package hdc_pkg;

    // byte offsets of the configuration map slice
    localparam logic [7:0] HDC_OFS_SP_CUR       = 8'h0e;
    localparam logic [7:0] HDC_OFS_BP_CUR       = 8'h0f;
    localparam logic [7:0] HDC_OFS_PWR_ON       = 8'h10;
    localparam logic [7:0] HDC_OFS_LANG_UPPER   = 8'h11;
    localparam logic [7:0] HDC_OFS_LANG_LOWER   = 8'h12;
    localparam logic [7:0] HDC_OFS_MAKER_LEN    = 8'h13;
    localparam logic [7:0] HDC_OFS_PRODUCT_LEN  = 8'h14;
    localparam logic [7:0] HDC_OFS_SERIAL_LEN   = 8'h15;
    localparam logic [7:0] HDC_OFS_MAKER_FIRST  = 8'h16;
    localparam logic [7:0] HDC_OFS_MAKER_LAST   = 8'h53;
    localparam logic [7:0] HDC_OFS_PRODUCT_LAST = 8'h91;

    // reset values
    localparam logic [7:0] HDC_RST_SP_CUR      = 8'h02;
    localparam logic [7:0] HDC_RST_BP_CUR      = 8'h64;
    localparam logic [7:0] HDC_RST_PWR_ON      = 8'h00;
    localparam logic [7:0] HDC_RST_LANG_UPPER  = 8'h04;
    localparam logic [7:0] HDC_RST_LANG_LOWER  = 8'h09;
    localparam logic [7:0] HDC_RST_LEN         = 8'h00;
    localparam logic [7:0] HDC_RST_TEXT        = 8'h00;

    // string storage geometry and scalar register count
    localparam int         HDC_TEXT_BYTES      = 124;
    localparam logic [6:0] HDC_STR_BYTES       = 7'h3e;
    localparam logic [4:0] HDC_LAST_CHAR       = 5'h1e;
    localparam int         HDC_SCALARS         = 8;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hdc_cfg_req_t;

    typedef struct packed {
        logic [7:0]  self_powered_controller_current;
        logic [7:0]  bus_powered_controller_current;
        logic [7:0]  power_on_to_good_time;
        logic [15:0] language_id;
        logic [7:0]  maker_text_length;
        logic [7:0]  product_text_length;
        logic [7:0]  serial_text_length;
    } hdc_desc_values_t;

    typedef enum logic [0:0] {
        HDC_TEXT_MAKER   = 1'b0,
        HDC_TEXT_PRODUCT = 1'b1
    } hdc_text_sel_t;

    // reset value of a scalar register by its index from the first offset
    function automatic logic [7:0] hdc_scalar_reset(input logic [2:0] idx);
        logic [7:0] v;
        v = HDC_RST_LEN;
        unique case (idx)
            3'h0: v = HDC_RST_SP_CUR;
            3'h1: v = HDC_RST_BP_CUR;
            3'h2: v = HDC_RST_PWR_ON;
            3'h3: v = HDC_RST_LANG_UPPER;
            3'h4: v = HDC_RST_LANG_LOWER;
            3'h5: v = HDC_RST_LEN;
            3'h6: v = HDC_RST_LEN;
            3'h7: v = HDC_RST_LEN;
        endcase
        return v;
    endfunction

endpackage

/* hdc_text_mem.sv */
// hdc_text_mem: byte store for the maker and product strings, registered read data
// assumes write and read indices are in range; callers decode the address first
`timescale 1ns/100ps
module hdc_text_mem (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wr_en,
    input  wire logic [6:0]  wr_idx,
    input  wire logic [7:0]  wr_data,
    input  wire logic [6:0]  rd_idx,
    output logic [7:0]       rd_data_q,
    input  wire logic [6:0]  char_base,
    output logic [15:0]      char_data_q
);
    logic [7:0] mem_q [hdc_pkg::HDC_TEXT_BYTES];
    logic [6:0] char_next;

    assign char_next = char_base + 7'h01;

    // flops rather than a ram macro: every byte must clear on reset
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < hdc_pkg::HDC_TEXT_BYTES; i++)
                mem_q[i] <= hdc_pkg::HDC_RST_TEXT;
        end
        else if (wr_en)
            mem_q[wr_idx] <= wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rd_data_q   <= hdc_pkg::HDC_RST_TEXT;
            char_data_q <= {hdc_pkg::HDC_RST_TEXT, hdc_pkg::HDC_RST_TEXT};
        end
        else
        begin
            rd_data_q   <= mem_q[rd_idx];
            char_data_q <= {mem_q[char_next], mem_q[char_base]};
        end
    end
endmodule // hdc_text_mem
